// ===== hw/asm_pkg.sv
// Package of offsets, field positions and reset values for the status and mode registers
package asm_pkg;
  // Register indices; byte address is four times the index
  localparam logic [3:0] ASM_IDX_STATUS = 4'h1;
  localparam logic [3:0] ASM_IDX_MODE = 4'h2;
  localparam logic [3:0] ASM_IDX_CLOCK = 4'h3;
  localparam int ASM_ADDR_LSB = 2;
  localparam int ASM_IDX_W = 4;
  // Reset values
  localparam logic [15:0] ASM_MODE_RST = 16'h0510;
  localparam logic [15:0] ASM_STATUS_RST = 16'h0500;
  localparam logic [2:0] ASM_CH_EN_RST = 3'h7;
  // Status field positions
  localparam int ASM_ST_LOCK = 15;
  localparam int ASM_ST_RESYNC = 14;
  localparam int ASM_ST_MAPCRC = 13;
  localparam int ASM_ST_CRCERR = 12;
  localparam int ASM_ST_CRCTYPE = 11;
  localparam int ASM_ST_RESET = 10;
  localparam int ASM_ST_WL_LO = 8;
  // Mode field positions
  localparam int ASM_MD_MAPCRC_EN = 13;
  localparam int ASM_MD_RXCRC_EN = 12;
  localparam int ASM_MD_CRCTYPE = 11;
  localparam int ASM_MD_RESET = 10;
  localparam int ASM_MD_WL_LO = 8;
  localparam int ASM_MD_TIMEOUT = 4;
  localparam int ASM_MD_SEL_LO = 2;
  localparam int ASM_MD_FLOAT = 1;
  localparam int ASM_MD_PULSE = 0;
  // Writable mode bits; reserved 15:14 and 7:5 read back zero
  localparam logic [15:0] ASM_MODE_WMASK = 16'h3f1f;
  // Clock configuration channel enables at bits 10:8
  localparam int ASM_CK_EN_LO = 8;
  // Ready pin pulse width
  localparam int ASM_PULSE_NS = 40;
  localparam int ASM_CLK_MHZ = 100;
  localparam int ASM_PULSE_CYC = (ASM_PULSE_NS * ASM_CLK_MHZ + 999) / 1000;
  // Ready pin source encodings
  localparam logic [1:0] ASM_SEL_LAG = 2'h0;
  localparam logic [1:0] ASM_SEL_OR = 2'h1;
  // AHB transfer type
  localparam logic [1:0] ASM_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] ASM_HSIZE_WORD = 3'h2;
  localparam int ASM_NCH = 3;
endpackage : asm_pkg

// ===== hw/asm_ready_pin.sv
// Data-ready pin driver: source selection, idle level and pulse shaping
`timescale 1ns/1ps
module asm_ready_pin
  import asm_pkg::*;
#(
  parameter int NCH = ASM_NCH,
  parameter int PULSE_CYC = ASM_PULSE_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Configuration
  input wire logic [1:0] src_sel,
  input wire logic idle_float,
  input wire logic pulse_fmt,
  input wire logic [NCH-1:0] ch_enable,
  // Per channel pending data
  input wire logic [NCH-1:0] ch_new_data,
  // Pin
  output logic pin_o_r,
  output logic pin_oe_n_r
);
  logic [NCH-1:0] act;
  logic all_en;
  logic any_en;
  logic src;
  logic src_d_r;
  logic [7:0] pulse_cnt_r;

  assign act = ch_new_data & ch_enable;
  assign all_en = ((ch_new_data | ~ch_enable) == {NCH{1'b1}}) && (ch_enable != '0);
  assign any_en = |act;

  always_comb begin
    case (src_sel)
      ASM_SEL_LAG: src = all_en;
      ASM_SEL_OR: src = any_en;
      default: src = any_en;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      src_d_r <= 1'b0;
    end else begin
      src_d_r <= src;
    end
  end

  // Pulse restarts only on a fresh rising source
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pulse_cnt_r <= 8'h00;
    end else if (src && !src_d_r) begin
      pulse_cnt_r <= 8'(PULSE_CYC);
    end else if (pulse_cnt_r != 8'h00) begin
      pulse_cnt_r <= pulse_cnt_r - 8'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pin_o_r <= 1'b1;
      pin_oe_n_r <= 1'b0;
    end else begin
      logic low;
      low = 1'b0;
      low = pulse_fmt ? ((src && !src_d_r) || (pulse_cnt_r > 8'h01)) : src;
      pin_o_r <= !low;
      pin_oe_n_r <= !low && idle_float;
    end
  end

  held_low_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (!pulse_fmt && src) |=> (!pin_o_r && !pin_oe_n_r)) else $error("ready pin not low");
  idle_level_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (!src && !src_d_r && pulse_cnt_r == 8'h00 && !idle_float) |=> (pin_o_r && !pin_oe_n_r))
    else $error("ready pin idle not high");
  idle_float_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (!src && !src_d_r && pulse_cnt_r == 8'h00 && idle_float) |=> pin_oe_n_r)
    else $error("ready pin idle not floating");
endmodule : asm_ready_pin

// ===== hw/asm_regs.sv
// Status and mode register bank with AHB-Lite slave and data-ready pin
// Notes on behaviour
// - Status bit 15 shows interface lock, 0 unlocked at reset.
// - Status bit 14 is set on each converter resynchronization.
// - Status bit 13 is set when the register map checksum changes.
// - Status bit 12 is set on a serial input checksum error.
// - Mode bit 11 picks CCITT (0) or ANSI (1) polynomial.
// - Status bits 11 and 9:8 mirror mode polynomial and word length.
// - Reset flag at status bit 10 reads 1; host clears via mode bit 10.
// - Mode bits 9:8 set word length, default 24 bits.
// - Status bits 2:0 flag new data per channel.
// - Mode bit 13 enables register map checksum, off at reset.
// - Mode bit 12 enables serial input checksum, off at reset.
// - Mode bits 3:2 choose lagging, OR or leading ready source.
// - Idle ready pin is high, or floats when mode bit 1 set.
// - Ready pin held low, or a fixed low pulse when mode bit 0 set.
// - Mode word at index 2, reset 0510h.
// - Status word at index 1, reset 0500h.
// - Only enabled channels, clock word bits 10:8, drive the ready pin.
`timescale 1ns/1ps
module asm_regs
  import asm_pkg::*;
#(
  parameter int NCH = ASM_NCH,
  parameter int PULSE_CYC = ASM_PULSE_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Converter events, pulses or levels from core logic
  input wire logic if_locked,
  input wire logic resync_evt,
  input wire logic map_crc_change_evt,
  input wire logic rx_crc_err_evt,
  input wire logic [NCH-1:0] ch_data_set,
  input wire logic [NCH-1:0] ch_data_taken,
  // Configuration outputs
  output logic map_crc_en_r,
  output logic rx_crc_en_r,
  output logic crc_ansi_r,
  output logic [1:0] word_length_sel_r,
  output logic timeout_en_r,
  // Data-ready pin
  output logic data_ready_pin_o,
  output logic data_ready_pin_oe_n
);
  logic [15:0] mode_r;
  logic [2:0] ch_en_r;
  logic lock_r;
  logic resync_flag_r;
  logic map_crc_flag_r;
  logic crc_err_flag_r;
  logic reset_flag_r;
  logic [NCH-1:0] new_data_r;
  logic wr_pend_r;
  logic [ASM_IDX_W-1:0] idx_r;
  logic [15:0] status_word;
  logic [15:0] rd_word;
  logic addr_ok;
  logic take;

  function automatic logic [ASM_IDX_W-1:0] to_idx(input logic [31:0] a);
    to_idx = a[ASM_ADDR_LSB +: ASM_IDX_W];
  endfunction : to_idx

  function automatic logic mapped(input logic [31:0] a);
    mapped = (a[31:ASM_ADDR_LSB + ASM_IDX_W] == '0) && (a[ASM_ADDR_LSB-1:0] == '0);
  endfunction : mapped

  assign take = hsel && hready && (htrans == ASM_HTRANS_NONSEQ) && (hsize == ASM_HSIZE_WORD);
  assign addr_ok = mapped(haddr);

  // Zero wait states; reads use the mode state current at the read address phase, so a write in the directly preceding transfer is not yet seen
  // Held in flops so every top output comes from a register; values never change
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wr_pend_r <= 1'b0;
      idx_r <= '0;
    end else begin
      wr_pend_r <= take && hwrite && addr_ok;
      idx_r <= to_idx(haddr);
    end
  end

  // Mode register write in data phase; reserved bits dropped
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mode_r <= ASM_MODE_RST;
    end else if (wr_pend_r && idx_r == ASM_IDX_MODE) begin
      mode_r <= hwdata[15:0] & ASM_MODE_WMASK;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ch_en_r <= ASM_CH_EN_RST;
    end else if (wr_pend_r && idx_r == ASM_IDX_CLOCK) begin
      ch_en_r <= hwdata[ASM_CK_EN_LO +: 3];
    end
  end

  always_comb begin
    map_crc_en_r = mode_r[ASM_MD_MAPCRC_EN];
    rx_crc_en_r = mode_r[ASM_MD_RXCRC_EN];
    crc_ansi_r = mode_r[ASM_MD_CRCTYPE];
    word_length_sel_r = mode_r[ASM_MD_WL_LO +: 2];
    timeout_en_r = mode_r[ASM_MD_TIMEOUT];
  end

  // Sticky event flags and the registered lock level; status writes never touch them
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lock_r <= 1'b0;
      resync_flag_r <= 1'b0;
      map_crc_flag_r <= 1'b0;
      crc_err_flag_r <= 1'b0;
    end else begin
      lock_r <= if_locked;
      resync_flag_r <= resync_flag_r | resync_evt;
      map_crc_flag_r <= map_crc_flag_r | map_crc_change_evt;
      crc_err_flag_r <= crc_err_flag_r | rx_crc_err_evt;
    end
  end

  // Cleared by writing 0 to mode bit 10
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reset_flag_r <= 1'b1;
    end else if (wr_pend_r && idx_r == ASM_IDX_MODE && !hwdata[ASM_MD_RESET]) begin
      reset_flag_r <= 1'b0;
    end
  end

  // Set beats take per channel so a fresh sample is never lost
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          new_data_r[gi] <= 1'b0;
        end else if (ch_data_set[gi]) begin
          new_data_r[gi] <= 1'b1;
        end else if (ch_data_taken[gi]) begin
          new_data_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_comb begin
    status_word = '0;
    status_word[ASM_ST_LOCK] = lock_r;
    status_word[ASM_ST_RESYNC] = resync_flag_r;
    status_word[ASM_ST_MAPCRC] = map_crc_flag_r;
    status_word[ASM_ST_CRCERR] = crc_err_flag_r;
    status_word[ASM_ST_CRCTYPE] = mode_r[ASM_MD_CRCTYPE];
    status_word[ASM_ST_RESET] = reset_flag_r;
    status_word[ASM_ST_WL_LO +: 2] = mode_r[ASM_MD_WL_LO +: 2];
    status_word[NCH-1:0] = new_data_r;
  end

  always_comb begin
    case (to_idx(haddr))
      ASM_IDX_STATUS: rd_word = status_word;
      ASM_IDX_MODE: rd_word = mode_r;
      ASM_IDX_CLOCK: rd_word = {5'h00, ch_en_r, 8'h00};
      default: rd_word = 16'h0000;
    endcase
  end

  // Read data registered at the address phase; unmapped reads give zero
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      hrdata <= addr_ok ? {16'h0000, rd_word} : 32'h0000_0000;
    end
  end

  asm_ready_pin #(
    .NCH(NCH),
    .PULSE_CYC(PULSE_CYC)
  ) u_pin (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .src_sel(mode_r[ASM_MD_SEL_LO +: 2]),
    .idle_float(mode_r[ASM_MD_FLOAT]),
    .pulse_fmt(mode_r[ASM_MD_PULSE]),
    .ch_enable(ch_en_r[NCH-1:0]),
    .ch_new_data(new_data_r),
    .pin_o_r(data_ready_pin_o),
    .pin_oe_n_r(data_ready_pin_oe_n)
  );

  sequence mode_clear_wr_s;
    wr_pend_r && idx_r == ASM_IDX_MODE && !hwdata[ASM_MD_RESET];
  endsequence

  reset_clear_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    mode_clear_wr_s |=> !reset_flag_r) else $error("reset flag not cleared");
  reset_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (reset_flag_r && !(wr_pend_r && idx_r == ASM_IDX_MODE)) |=> reset_flag_r)
    else $error("reset flag lost");
  resync_sticky_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    resync_evt |=> resync_flag_r [*2]) else $error("resync flag not sticky");
  crc_err_set_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    rx_crc_err_evt |=> status_word[ASM_ST_CRCERR]) else $error("crc error flag not set");
  map_crc_set_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    map_crc_change_evt |=> status_word[ASM_ST_MAPCRC]) else $error("map crc flag not set");
  mirror_copy_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (take && !hwrite && addr_ok && to_idx(haddr) == ASM_IDX_STATUS) |=>
    (hrdata[ASM_ST_WL_LO +: 2] == $past(mode_r[ASM_MD_WL_LO +: 2])
    && hrdata[ASM_ST_CRCTYPE] == $past(mode_r[ASM_MD_CRCTYPE])))
    else $error("status mirror mismatch");
  status_rsvd_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (take && !hwrite && addr_ok && to_idx(haddr) == ASM_IDX_STATUS) |=> hrdata[7:3] == 5'h00)
    else $error("reserved status bits nonzero");
  status_wr_ign_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (wr_pend_r && idx_r == ASM_IDX_STATUS) |=> $stable(mode_r) && reset_flag_r == $past(reset_flag_r))
    else $error("status write changed state");
  new_data_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    ch_data_set[0] |=> new_data_r[0]) else $error("new data flag not set");
  lock_follow_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    if_locked |=> lock_r) else $error("lock not reported");
endmodule : asm_regs

// ===== dv/asm_core_model.sv
// Converter core stand-in: turns bench requests into event pulses and a lock level
`timescale 1ns/1ps
module asm_core_model
  import asm_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Requests from the bench
  input wire logic [2:0] req_evt,
  input wire logic [ASM_NCH-1:0] req_set,
  input wire logic [ASM_NCH-1:0] req_take,
  input wire logic req_lock,
  // Toward the register bank
  output logic if_locked,
  output logic resync_evt,
  output logic map_crc_change_evt,
  output logic rx_crc_err_evt,
  output logic [ASM_NCH-1:0] ch_data_set,
  output logic [ASM_NCH-1:0] ch_data_taken
);
  // Registered, so every event reaches the bank one cycle after its request, as wide as the request
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      {rx_crc_err_evt, map_crc_change_evt, resync_evt} <= 3'h0;
      ch_data_set <= '0;
      ch_data_taken <= '0;
      if_locked <= 1'b0;
    end else begin
      {rx_crc_err_evt, map_crc_change_evt, resync_evt} <= req_evt;
      ch_data_set <= req_set;
      ch_data_taken <= req_take;
      if_locked <= req_lock;
    end
  end
endmodule : asm_core_model

// ===== dv/asm_regs_test.sv
// Self-checking bench for the status and mode register bank
`timescale 1ns/1ps
module asm_regs_test
  import asm_pkg::*;
;
  logic ref_clk, nrst, hsel, hwrite, hreadyout, hresp, req_lock, rflag;
  logic [31:0] haddr, hwdata, hrdata, seed, rd;
  logic [1:0] htrans, wl;
  logic [2:0] req_evt, req_set, req_take, ch_set, ch_take;
  logic lock, rsy, mce, rce, mcrc, rcrc, ansi, tmo, pin, pin_oe_n;
  logic [15:0] mode_e, v;
  logic [3:0] ev;
  int fail_count, tests_run, i, cnt;

  asm_core_model core (.ref_clk(ref_clk), .nrst(nrst), .req_evt(req_evt), .req_set(req_set),
    .req_take(req_take), .req_lock(req_lock), .if_locked(lock), .resync_evt(rsy),
    .map_crc_change_evt(mce), .rx_crc_err_evt(rce), .ch_data_set(ch_set), .ch_data_taken(ch_take));
  asm_regs uut (.ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(ASM_HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .if_locked(lock), .resync_evt(rsy),
    .map_crc_change_evt(mce), .rx_crc_err_evt(rce), .ch_data_set(ch_set), .ch_data_taken(ch_take),
    .map_crc_en_r(mcrc), .rx_crc_en_r(rcrc), .crc_ansi_r(ansi), .word_length_sel_r(wl),
    .timeout_en_r(tmo), .data_ready_pin_o(pin), .data_ready_pin_oe_n(pin_oe_n));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic logic [31:0] stat(input logic [2:0] c);
    return {16'h0, ev, mode_e[11], rflag, mode_e[9:8], 5'h0, c};
  endfunction : stat

  // Lagging needs every enabled channel; OR and leading need any one
  function automatic logic act(input logic [1:0] s, input logic [2:0] e, input logic [2:0] d);
    return (s == 2'h0) ? (e != 3'h0 && (d & e) == e) : ((d & e) != 3'h0);
  endfunction : act

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] r);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= ASM_HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus

  task automatic reset_checks();
    mode_e = 16'h0510;
    rflag = 1'b1;
    ev = 4'h0;
    bus(1'b0, 32'h4, 32'h0, rd);
    check(rd, 32'h0500, "status reset");
    bus(1'b0, 32'h8, 32'h0, rd);
    check(rd, 32'h0510, "mode reset");
    check({mcrc, rcrc, ansi, wl, tmo, pin, pin_oe_n, hresp}, 32'h1c, "outputs reset");
  endtask : reset_checks

  // lo holds source select, idle float and pulse format
  task automatic pin_case(input logic [3:0] lo, input logic [2:0] e, input logic [2:0] d);
    logic a;
    a = act(lo[3:2], e, d);
    mode_e = 16'h0010 | 16'(lo);
    bus(1'b1, 32'h8, {16'h0, mode_e}, rd);
    bus(1'b1, 32'hc, {21'h0, e, 8'h0}, rd);
    cnt = 0;
    @(posedge ref_clk);
    req_set <= d;
    @(posedge ref_clk);
    req_set <= 3'h0;
    repeat (16) begin
      @(posedge ref_clk);
      if (pin === 1'b0 && pin_oe_n === 1'b0) cnt++;
    end
    if (lo[0]) check(32'(cnt), a ? ASM_PULSE_CYC : 0, "pulse width");
    else check({pin_oe_n, pin | (lo[1] & !a)}, {lo[1] & !a, !a}, "ready level");
    if (e == 3'h7) begin
      bus(1'b0, 32'h4, 32'h0, rd);
      check(rd, stat(d), "pending flags");
    end
    @(posedge ref_clk);
    req_take <= d;
    @(posedge ref_clk);
    req_take <= 3'h0;
    repeat (4) @(posedge ref_clk);
    check({pin_oe_n, pin | lo[1]}, {lo[1], 1'b1}, "idle pin");
    bus(1'b0, 32'h4, 32'h0, rd);
    check(rd, stat(3'h0), "flags taken");
  endtask : pin_case

  task automatic close_out();
    $display("Comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    close_out();
  end

  initial begin
    seed = 32'hfe2cc6a2;
    fail_count = 0;
    tests_run = 0;
    {nrst, hsel, hwrite, req_lock, htrans, haddr, hwdata} = '0;
    {req_evt, req_set, req_take} = '0;
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    reset_checks();
    bus(1'b0, 32'h40, 32'h0, rd);
    check(rd, 32'h0, "unmapped read");
    bus(1'b1, 32'h4, 32'hffff, rd);
    bus(1'b0, 32'h4, 32'h0, rd);
    check(rd, stat(3'h0), "status write");
    for (i = 0; i < 12; i++) begin
      v = 16'(xs()) & ASM_MODE_WMASK;
      v[9:8] = i[1:0];
      v[10] = 1'(i < 6);
      bus(1'b1, 32'h8, {16'h0, v}, rd);
      mode_e = v;
      rflag = rflag & v[10];
      bus(1'b0, 32'h4, 32'h0, rd);
      check(rd, stat(3'h0), "status mirror");
      bus(1'b0, 32'h8, 32'h0, rd);
      check(rd, {16'h0, v}, "mode readback");
      check({mcrc, rcrc, ansi, wl, tmo}, {v[13:11], v[9:8], v[4]}, "mode outputs");
    end
    req_evt <= 3'h7;
    req_lock <= 1'b1;
    @(posedge ref_clk);
    req_evt <= 3'h0;
    repeat (3) @(posedge ref_clk);
    ev = 4'hf;
    bus(1'b0, 32'h4, 32'h0, rd);
    check(rd, stat(3'h0), "event flags");
    req_lock <= 1'b0;
    repeat (3) @(posedge ref_clk);
    ev = 4'h7;
    bus(1'b0, 32'h4, 32'h0, rd);
    check(rd, stat(3'h0), "unlocked sticky");
    pin_case(4'h0, 3'h7, 3'h3);
    pin_case(4'h0, 3'h7, 3'h7);
    pin_case(4'h6, 3'h7, 3'h1);
    pin_case(4'h9, 3'h7, 3'h4);
    pin_case(4'hc, 3'h1, 3'h6);
    pin_case(4'h0, 3'h3, 3'h3);
    for (i = 0; i < 6; i++) pin_case(4'(xs()), 3'(xs()), 3'(xs()));
    @(posedge ref_clk);
    nrst <= 1'b0;
    @(posedge ref_clk);
    nrst <= 1'b1;
    reset_checks();
    close_out();
  end
endmodule : asm_regs_test
